//--- logic/qdsl_pkg.sv
// What this block does
// - 24-bit word, MSB first, address broadcast code
// - broadcast bit loads all four input registers
// - reset rise sets zero or mid-scale
// - input registers transparent while load low
// - output registers capture on update rising edge
// - one update edge moves all channels together
// - input writes never disturb output registers
// - shift clock is select OR serial clock
// - select rising with clock low shifts once
// - controller raises select only while clock high
// - controller keeps select high during load, reset
// - shifting during load follows address bits live
// - reset leaves the shift register unchanged
// - serial output is last stage, actively driven
// - daisy chain: serial out feeds next input
// - select may stay low for single device
// - code is straight unsigned binary
`default_nettype none
package qdsl_pkg;

   // ----------------------------------------------------------------
   // serial word layout
   // ----------------------------------------------------------------
   localparam int WORD_BITS    = 24;
   localparam int CODE_BITS    = 16;
   localparam int NUM_CHAN     = 4;
   localparam int POS_CHAN_HI  = 23;
   localparam int POS_CHAN_LO  = 22;
   localparam int POS_BCAST    = 21;
   localparam int POS_CODE_MSB = 15;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [CODE_BITS-1:0] ZERO_SCALE = 16'h0000;
   localparam logic [CODE_BITS-1:0] MID_SCALE  = 16'h8000;

   // ----------------------------------------------------------------
   // controller register map
   // ----------------------------------------------------------------
   localparam int             ADDR_BITS = 8;
   localparam int             DATA_BITS = 32;
   localparam logic [7:0]     REG_WORD  = 8'h00;
   localparam logic [7:0]     REG_CMD   = 8'h04;
   localparam logic [7:0]     REG_STAT  = 8'h08;
   localparam logic [7:0]     REG_ECHO  = 8'h0C;
   localparam int             CMD_SHIFT = 0;
   localparam int             CMD_LOAD  = 1;
   localparam int             CMD_UPD   = 2;
   localparam int             CMD_RST   = 3;
   localparam int             CMD_RSEL  = 4;
   localparam int             STAT_BUSY = 0;
   localparam logic [31:0]    CMD_RESET_VAL = 32'h0000_0000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 25;
   localparam int SCLK_HIGH_NS   = 25;
   localparam int UPD_HIGH_NS    = 150;
   // at least two cycles per half so select can rise inside the high phase
   localparam int SCLK_HALF_CYC  = ((SCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 2 ? 2 :
                                   ((SCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int UPD_HIGH_CYC   = (UPD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // device samples strobes through two stages plus an edge stage
   localparam int HOLD_PERIODS   = (UPD_HIGH_CYC / (2 * SCLK_HALF_CYC)) + 4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SHIFT,
      ST_LOAD,
      ST_UPD,
      ST_RST
   } qdsl_state_t;

endpackage : qdsl_pkg
`default_nettype wire

//--- logic/qdsl_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qdsl_link_if;
   logic sclk;
   logic sel_n;
   logic serial_in;
   logic load_n;
   logic output_update;
   logic reset_pin;
   logic reset_level_select;
   logic serial_out;

   modport dev (
      input  sclk,
      input  sel_n,
      input  serial_in,
      input  load_n,
      input  output_update,
      input  reset_pin,
      input  reset_level_select,
      output serial_out
   );

   modport host (
      output sclk,
      output sel_n,
      output serial_in,
      output load_n,
      output output_update,
      output reset_pin,
      output reset_level_select,
      input  serial_out
   );
endinterface : qdsl_link_if
`default_nettype wire

//--- logic/qdsl_device.sv
`timescale 1ns/1ps
`default_nettype none
module qdsl_device
   import qdsl_pkg::*;
(
   input  wire logic                                 i_sys_rst,
   qdsl_link_if.dev                                  link,
   output logic [NUM_CHAN-1:0][CODE_BITS-1:0]        o_in_code,
   output logic [NUM_CHAN-1:0][CODE_BITS-1:0]        o_out_code,
   output logic [WORD_BITS-1:0]                      o_word
);

   // ----------------------------------------------------------------
   // shift register
   // ----------------------------------------------------------------
   logic                 shift_clk;
   logic [WORD_BITS-1:0] shift_reg;
   logic [WORD_BITS-1:0] shift_next;

   // either input may act as the clock; a select rise with sclk low
   // is an edge too and shifts one extra bit
   assign shift_clk = link.sel_n | link.sclk;

   always_comb begin
      shift_next = {shift_reg[WORD_BITS-2:0], link.serial_in};
   end

   // the reset pin is not in this sensitivity list on purpose
   always_ff @(posedge shift_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         shift_reg <= '0;
      end else begin
         shift_reg <= shift_next;
      end
   end

   // last stage driven straight out, no pull-up needed
   assign link.serial_out = shift_reg[WORD_BITS-1];

   // ----------------------------------------------------------------
   // synchronisers into the sclk domain
   // ----------------------------------------------------------------
   // sclk must run free for strobes and resets to be seen
   logic                 ld_s1_reg;
   logic                 ld_s2_reg;
   logic                 upd_s1_reg;
   logic                 upd_s2_reg;
   logic                 upd_s3_reg;
   logic                 rp_s1_reg;
   logic                 rp_s2_reg;
   logic                 rp_s3_reg;
   logic                 rs_s1_reg;
   logic                 rs_s2_reg;
   logic [WORD_BITS-1:0] word_s1_reg;
   logic [WORD_BITS-1:0] word_s2_reg;
   logic [WORD_BITS-1:0] word_s3_reg;

   always_ff @(posedge link.sclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ld_s1_reg   <= 1'b1;
         ld_s2_reg   <= 1'b1;
         upd_s1_reg  <= 1'b1;
         upd_s2_reg  <= 1'b1;
         upd_s3_reg  <= 1'b1;
         rp_s1_reg   <= 1'b0;
         rp_s2_reg   <= 1'b0;
         rp_s3_reg   <= 1'b0;
         rs_s1_reg   <= 1'b0;
         rs_s2_reg   <= 1'b0;
         word_s1_reg <= '0;
         word_s2_reg <= '0;
         word_s3_reg <= '0;
      end else begin
         ld_s1_reg   <= link.load_n;
         ld_s2_reg   <= ld_s1_reg;
         upd_s1_reg  <= link.output_update;
         upd_s2_reg  <= upd_s1_reg;
         upd_s3_reg  <= upd_s2_reg;
         rp_s1_reg   <= link.reset_pin;
         rp_s2_reg   <= rp_s1_reg;
         rp_s3_reg   <= rp_s2_reg;
         rs_s1_reg   <= link.reset_level_select;
         rs_s2_reg   <= rs_s1_reg;
         word_s1_reg <= shift_reg;
         word_s2_reg <= word_s1_reg;
         word_s3_reg <= word_s2_reg;
      end
   end

   // ----------------------------------------------------------------
   // decode of the settled word
   // ----------------------------------------------------------------
   logic                 word_stable;
   logic                 rst_rise;
   logic                 upd_rise;
   logic [1:0]           chan_sel;
   logic                 bcast;
   logic [CODE_BITS-1:0] code;
   logic [CODE_BITS-1:0] rst_code;

   // a multi-bit word is only used once two samples agree
   assign word_stable = (word_s2_reg == word_s3_reg);
   assign rst_rise    = rp_s2_reg & ~rp_s3_reg;
   assign upd_rise    = upd_s2_reg & ~upd_s3_reg;
   assign chan_sel    = {word_s3_reg[POS_CHAN_HI], word_s3_reg[POS_CHAN_LO]};
   assign bcast       = word_s3_reg[POS_BCAST];
   // straight binary, no offset coding applied
   assign code        = word_s3_reg[POS_CODE_MSB:0];
   assign rst_code    = rs_s2_reg ? MID_SCALE : ZERO_SCALE;

   // ----------------------------------------------------------------
   // input and output registers
   // ----------------------------------------------------------------
   logic [NUM_CHAN-1:0][CODE_BITS-1:0] in_reg;
   logic [NUM_CHAN-1:0][CODE_BITS-1:0] in_next;
   logic [NUM_CHAN-1:0][CODE_BITS-1:0] out_reg;
   logic [NUM_CHAN-1:0][CODE_BITS-1:0] out_next;

   genvar c;
   generate
      for (c = 0; c < NUM_CHAN; c++) begin : g_chan
         logic chan_hit;

         assign chan_hit = bcast | (chan_sel == 2'(c));

         always_comb begin
            in_next[c]  = in_reg[c];
            out_next[c] = out_reg[c];
            if (rst_rise) begin
               in_next[c]  = rst_code;
               out_next[c] = rst_code;
            end else if (!rp_s2_reg) begin
               // level load: any settled word that passes while load
               // is low lands in whichever channel it addresses
               if (!ld_s2_reg && word_stable && chan_hit) begin
                  in_next[c] = code;
               end
               // outputs move here and on a reset rise, all channels on one edge
               if (upd_rise) begin
                  out_next[c] = in_reg[c];
               end
            end
         end

         always_ff @(posedge link.sclk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               in_reg[c]  <= ZERO_SCALE;
               out_reg[c] <= ZERO_SCALE;
            end else begin
               in_reg[c]  <= in_next[c];
               out_reg[c] <= out_next[c];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // user-side view
   // ----------------------------------------------------------------
   assign o_in_code  = in_reg;
   assign o_out_code = out_reg;
   assign o_word     = word_s3_reg;

endmodule : qdsl_device
`default_nettype wire

//--- logic/qdsl_host.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module qdsl_host
   import qdsl_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC,
   parameter int HOLD     = HOLD_PERIODS
)(
   input  wire logic                 i_clk,
   input  wire logic                 i_sys_rst,
   input  wire logic [ADDR_BITS-1:0] i_addr,
   input  wire logic [DATA_BITS-1:0] i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic      [DATA_BITS-1:0] o_rdata,
   qdsl_link_if.host                 link
);

   // ----------------------------------------------------------------
   // registers and pins
   // ----------------------------------------------------------------
   qdsl_state_t          state_reg,   state_next;
   logic [3:0]           pend_reg,    pend_next;
   logic [WORD_BITS-1:0] word_reg,    word_next;
   logic [WORD_BITS-1:0] echo_reg,    echo_next;
   logic                 rsel_reg,    rsel_next;
   logic [7:0]           phase_reg,   phase_next;
   logic                 sclk_reg,    sclk_next;
   logic [4:0]           bit_reg,     bit_next;
   logic [7:0]           hold_reg,    hold_next;
   logic                 sel_n_reg,   sel_n_next;
   logic                 ser_in_reg,  ser_in_next;
   logic                 load_n_reg,  load_n_next;
   logic                 upd_reg,     upd_next;
   logic                 rpin_reg,    rpin_next;
   logic [DATA_BITS-1:0] rdata_reg,   rdata_next;
   logic                 so_s1_reg;
   logic                 so_s2_reg;
   logic                 wrap;
   logic                 rise_evt;
   logic                 fall_evt;
   logic                 busy;
   logic                 active;

   assign wrap     = (phase_reg == 8'(HALF_CYC - 1));
   assign rise_evt = wrap & ~sclk_reg;
   assign fall_evt = wrap & sclk_reg;
   assign busy     = (state_reg != ST_IDLE);
   assign active   = (hold_reg < 8'(HOLD));

   function automatic qdsl_state_t pick(input logic [3:0] p);
      if (p[CMD_SHIFT])     pick = ST_SHIFT;
      else if (p[CMD_LOAD]) pick = ST_LOAD;
      else if (p[CMD_UPD])  pick = ST_UPD;
      else if (p[CMD_RST])  pick = ST_RST;
      else                  pick = ST_IDLE;
   endfunction : pick

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next  = state_reg;
      pend_next   = pend_reg;
      word_next   = word_reg;
      echo_next   = echo_reg;
      rsel_next   = rsel_reg;
      bit_next    = bit_reg;
      hold_next   = hold_reg;
      sel_n_next  = sel_n_reg;
      ser_in_next = ser_in_reg;
      load_n_next = 1'b1;
      upd_next    = 1'b1;
      rpin_next   = 1'b0;
      rdata_next  = '0;
      // sclk runs free so the device can sample strobes
      phase_next  = wrap ? 8'h00 : phase_reg + 8'h01;
      sclk_next   = wrap ? ~sclk_reg : sclk_reg;

      if (i_rd) begin
         unique case (i_addr)
            REG_WORD: rdata_next = 32'(word_reg);
            REG_CMD:  rdata_next = 32'(rsel_reg) << CMD_RSEL;
            REG_STAT: rdata_next = 32'(busy) << STAT_BUSY;
            REG_ECHO: rdata_next = 32'(echo_reg);
            default:  rdata_next = '0;
         endcase
      end
      // writes while busy are dropped
      if (i_wr && !busy) begin
         if (i_addr == REG_WORD) begin
            word_next = i_wdata[WORD_BITS-1:0];
         end else if (i_addr == REG_CMD) begin
            pend_next  = i_wdata[CMD_RST:CMD_SHIFT];
            rsel_next  = i_wdata[CMD_RSEL];
            state_next = pick(i_wdata[CMD_RST:CMD_SHIFT]);
            bit_next   = 5'h00;
            hold_next  = 8'h00;
         end
      end

      unique case (state_reg)
         ST_IDLE: begin
         end
         ST_SHIFT: begin
            // data changes on the falling edge, device takes it on rise
            if (fall_evt && bit_reg < 5'(WORD_BITS)) begin
               sel_n_next  = 1'b0;
               ser_in_next = word_reg[5'(WORD_BITS - 1) - bit_reg];
            end
            if (rise_evt && !sel_n_reg) begin
               bit_next  = bit_reg + 5'h01;
               echo_next = {echo_reg[WORD_BITS-2:0], so_s2_reg};
            end
            // one cycle into the high phase, so the OR gate sees no edge
            if (bit_reg == 5'(WORD_BITS) && sclk_reg && !wrap) begin
               sel_n_next = 1'b1;
               pend_next  = pend_reg & ~(4'h1 << CMD_SHIFT);
               state_next = pick(pend_reg & ~(4'h1 << CMD_SHIFT));
            end
         end
         ST_LOAD, ST_UPD, ST_RST: begin
            // select stays high through these pulses
            if (state_reg == ST_LOAD) load_n_next = ~active;
            if (state_reg == ST_UPD)  upd_next    = ~active;
            if (state_reg == ST_RST)  rpin_next   = active;
            if (rise_evt) begin
               hold_next = hold_reg + 8'h01;
               if (hold_reg == 8'(2 * HOLD - 1)) begin
                  hold_next  = 8'h00;
                  pend_next  = pend_reg & ~(4'h1 << (int'(state_reg) - int'(ST_SHIFT)));
                  state_next = pick(pend_reg & ~(4'h1 << (int'(state_reg) - int'(ST_SHIFT))));
               end
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg  <= ST_IDLE;
         pend_reg   <= 4'h0;
         word_reg   <= '0;
         echo_reg   <= '0;
         rsel_reg   <= CMD_RESET_VAL[CMD_RSEL];
         phase_reg  <= 8'h00;
         sclk_reg   <= 1'b0;
         bit_reg    <= 5'h00;
         hold_reg   <= 8'h00;
         sel_n_reg  <= 1'b1;
         ser_in_reg <= 1'b0;
         load_n_reg <= 1'b1;
         upd_reg    <= 1'b1;
         rpin_reg   <= 1'b0;
         rdata_reg  <= '0;
         so_s1_reg  <= 1'b0;
         so_s2_reg  <= 1'b0;
      end else begin
         state_reg  <= state_next;
         pend_reg   <= pend_next;
         word_reg   <= word_next;
         echo_reg   <= echo_next;
         rsel_reg   <= rsel_next;
         phase_reg  <= phase_next;
         sclk_reg   <= sclk_next;
         bit_reg    <= bit_next;
         hold_reg   <= hold_next;
         sel_n_reg  <= sel_n_next;
         ser_in_reg <= ser_in_next;
         load_n_reg <= load_n_next;
         upd_reg    <= upd_next;
         rpin_reg   <= rpin_next;
         rdata_reg  <= rdata_next;
         so_s1_reg  <= link.serial_out;
         so_s2_reg  <= so_s1_reg;
      end
   end

   assign o_rdata                 = rdata_reg;
   assign link.sclk               = sclk_reg;
   assign link.sel_n              = sel_n_reg;
   assign link.serial_in          = ser_in_reg;
   assign link.load_n             = load_n_reg;
   assign link.output_update      = upd_reg;
   assign link.reset_pin          = rpin_reg;
   assign link.reset_level_select = rsel_reg;

endmodule : qdsl_host
`default_nettype wire

//--- verif/qdsl_props.sv
`timescale 1ns/1ps
`default_nettype none
module qdsl_props
   import qdsl_pkg::*;
(
   input wire logic                                i_clk,
   input wire logic                                i_sys_rst,
   input wire logic                                sclk,
   input wire logic                                sel_n,
   input wire logic                                load_n,
   input wire logic                                output_update,
   input wire logic                                reset_pin,
   input wire logic                                reset_level_select,
   input wire logic                                serial_out,
   input wire logic [NUM_CHAN-1:0][CODE_BITS-1:0]  o_in_code,
   input wire logic [NUM_CHAN-1:0][CODE_BITS-1:0]  o_out_code,
   input wire logic [WORD_BITS-1:0]                o_word
);
   // ------------------------------------------------------------
   // cycles since the last update or reset rising edge
   // ------------------------------------------------------------
   logic       upd_prev_reg;
   logic       upd_prev_next;
   logic       rst_prev_reg;
   logic       rst_prev_next;
   logic [5:0] evt_cnt_reg;
   logic [5:0] evt_cnt_next;

   always_comb begin
      upd_prev_next = output_update;
      rst_prev_next = reset_pin;
      if ((output_update && !upd_prev_reg) || (reset_pin && !rst_prev_reg)) begin
         evt_cnt_next = 6'h00;
      end else if (evt_cnt_reg != 6'h3F) begin
         evt_cnt_next = evt_cnt_reg + 6'h01;
      end else begin
         evt_cnt_next = evt_cnt_reg;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         upd_prev_reg <= 1'b1;
         rst_prev_reg <= 1'b0;
         evt_cnt_reg  <= 6'h3F;
      end else begin
         upd_prev_reg <= upd_prev_next;
         rst_prev_reg <= rst_prev_next;
         evt_cnt_reg  <= evt_cnt_next;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   sel_rise_a: assert property ($rose(sel_n) |-> sclk)
      else $error("select rose while serial clock low");
   sel_quiet_a: assert property ((!load_n || reset_pin) |-> sel_n)
      else $error("select low during load or reset");
   sout_shift_a: assert property ($changed(serial_out) |-> $rose(sclk | sel_n))
      else $error("serial out moved without a shift edge");
   word_rst_a: assert property (reset_pin |-> $stable(o_word))
      else $error("shift register moved during reset");
   in_hold_a: assert property ($changed(o_in_code) |-> (!load_n || reset_pin))
      else $error("input register changed with load high");
   in_value_a: assert property ($changed(o_in_code) && !reset_pin |->
      o_in_code[o_word[23:22]] == o_word[15:0]) else $error("addressed input register wrong");
   bcast_all_a: assert property ($changed(o_in_code) && !reset_pin && o_word[21] |->
      o_in_code == {NUM_CHAN{o_word[15:0]}}) else $error("broadcast missed a channel");
   out_cause_a: assert property ($changed(o_out_code) |-> evt_cnt_reg < 6'h28)
      else $error("output register changed without update edge");
   out_all_a: assert property ($changed(o_out_code) |-> o_out_code == o_in_code)
      else $error("output registers not all taken together");
   rst_level_a: assert property ($changed(o_out_code) && reset_pin |->
      o_out_code == {NUM_CHAN{reset_level_select ? MID_SCALE : ZERO_SCALE}})
      else $error("reset level wrong");

   upd_c: cover property ($rose(output_update));
   load_c: cover property ($fell(load_n));
   mid_c: cover property ($rose(reset_pin) && reset_level_select);
   zero_c: cover property ($rose(reset_pin) && !reset_level_select);
endmodule : qdsl_props
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import qdsl_pkg::*;
;
   logic                                i_clk     = 1'b0;
   logic                                i_sys_rst = 1'b1;
   logic [ADDR_BITS-1:0]                i_addr    = 8'h00;
   logic [DATA_BITS-1:0]                i_wdata   = 32'h0000_0000;
   logic                                i_wr      = 1'b0;
   logic                                i_rd      = 1'b0;
   logic [DATA_BITS-1:0]                o_rdata;
   logic [NUM_CHAN-1:0][CODE_BITS-1:0]  in_code;
   logic [NUM_CHAN-1:0][CODE_BITS-1:0]  out_code;
   logic [NUM_CHAN-1:0][CODE_BITS-1:0]  exp_in;
   logic [NUM_CHAN-1:0][CODE_BITS-1:0]  exp_out;
   logic [WORD_BITS-1:0]                o_word;
   logic [WORD_BITS-1:0]                prev_word;
   logic [WORD_BITS-1:0]                mon_reg   = 24'h000000;
   logic [31:0]                         rng       = 32'h0000_271A;
   int                                  fail_count = 0;
   int                                  checked    = 0;
   logic [23:0] corner [5] = '{24'h00FFFF, 24'h5F0001, 24'h808000, 24'hC0ABCD, 24'h201234};

   always #12.5 i_clk = ~i_clk;

   qdsl_link_if qdsl_link_if_i ();
   qdsl_host qdsl_host_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(qdsl_link_if_i));
   qdsl_device qdsl_device_i (.i_sys_rst(i_sys_rst), .link(qdsl_link_if_i), .o_in_code(in_code),
      .o_out_code(out_code), .o_word(o_word));
   qdsl_props qdsl_props_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .sclk(qdsl_link_if_i.sclk),
      .sel_n(qdsl_link_if_i.sel_n), .load_n(qdsl_link_if_i.load_n),
      .output_update(qdsl_link_if_i.output_update), .reset_pin(qdsl_link_if_i.reset_pin),
      .reset_level_select(qdsl_link_if_i.reset_level_select), .serial_out(qdsl_link_if_i.serial_out),
      .o_in_code(in_code), .o_out_code(out_code), .o_word(o_word));

   // wire monitor: bits as the device sees them, first bit ends up on top
   always @(posedge qdsl_link_if_i.sclk) begin
      if (!qdsl_link_if_i.sel_n) begin
         mon_reg <= {mon_reg[22:0], qdsl_link_if_i.serial_in};
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   function automatic logic hit(input logic [23:0] w, input logic [1:0] ch);
      return w[POS_BCAST] || (w[POS_CHAN_HI:POS_CHAN_LO] == ch);
   endfunction : hit

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : bus_rd

   // busy is only polled once the command has had time to start
   task automatic run_cmd(input logic [23:0] w, input logic [31:0] cmd);
      logic [31:0] st;
      int          n;
      bus_wr(REG_WORD, {8'h00, w});
      bus_wr(REG_CMD, cmd);
      repeat (3) @(posedge i_clk);
      st = 32'h0000_0001;
      n  = 0;
      while (st[STAT_BUSY] !== 1'b0 && n < 2000) begin
         bus_rd(REG_STAT, st);
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
         $display("mismatch busy expected 0 seen 1");
         complete_run();
      end
   endtask : run_cmd

   task automatic complete_run();
      $display("counts checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic [23:0] w;
      logic [31:0] rv;
      exp_in    = '0;
      exp_out   = '0;
      prev_word = 24'h000000;
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      check("in reset", in_code, 64'h0);
      check("out reset", out_code, 64'h0);
      bus_rd(REG_CMD, rv);
      check("cmd reset", {32'h0, rv}, {32'h0, CMD_RESET_VAL});
      bus_rd(8'h10, rv);
      check("unmapped", {32'h0, rv}, 64'h0);
      $display("test reset_state done");
      for (int k = 0; k < 16; k++) begin
         if (k < 5) begin
            w = corner[k];
         end else begin
            rng = xs(rng);
            w   = rng[23:0];
         end
         run_cmd(w, k[0] ? 32'h0000_0007 : 32'h0000_0003);
         for (int c = 0; c < NUM_CHAN; c++) begin
            if (hit(w, 2'(c))) begin
               exp_in[c] = w[15:0];
            end
         end
         if (k[0]) begin
            exp_out = exp_in;
         end
         check("wire word", {40'h0, mon_reg}, {40'h0, w});
         check("word", {40'h0, o_word}, {40'h0, w});
         check("in code", in_code, exp_in);
         check("out code", out_code, exp_out);
         check("serial out", {63'h0, qdsl_link_if_i.serial_out}, {63'h0, w[23]});
         bus_rd(REG_ECHO, rv);
         check("echo", {40'h0, rv[23:0]}, {40'h0, prev_word});
         prev_word = w;
      end
      bus_rd(REG_WORD, rv);
      check("word reg", {40'h0, rv[23:0]}, {40'h0, prev_word});
      $display("test load_update done");
      run_cmd(prev_word, 32'h0000_0018);
      check("mid in", in_code, {NUM_CHAN{MID_SCALE}});
      check("mid out", out_code, {NUM_CHAN{MID_SCALE}});
      check("word kept", {40'h0, o_word}, {40'h0, prev_word});
      bus_rd(REG_CMD, rv);
      check("rsel", {63'h0, rv[CMD_RSEL]}, 64'h1);
      // load, update and reset in one command: reset must have the last word
      run_cmd(prev_word, 32'h0000_0006 | 32'h0000_0008);
      check("zero in", in_code, {NUM_CHAN{ZERO_SCALE}});
      check("zero out", out_code, {NUM_CHAN{ZERO_SCALE}});
      rng = xs(rng);
      run_cmd(rng[23:0], 32'h0000_0001);
      bus_rd(REG_ECHO, rv);
      check("echo after reset", {40'h0, rv[23:0]}, {40'h0, prev_word});
      check("out after shift", out_code, 64'h0);
      check("in after shift", in_code, 64'h0);
      $display("test reset_pin done");
      complete_run();
   end

   initial begin
      #(25 * 60000);
      fail_count++;
      $display("mismatch watchdog expected done seen timeout");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
